/* File: core/dams_pkg.sv */
// Package for the dual axis microstep sequencer: resolutions, timing, widths.
// Assumes a 25 MHz system clock.
package dams_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int RES_W = 4;
	localparam int POS_W = 10;
	localparam int CUR_W = 8;
	localparam int ADC_W = 10;
	// Resolution codes, 15 settings
	localparam logic [RES_W-1:0] RES_FULL = 4'h0;
	localparam logic [RES_W-1:0] RES_HALF = 4'h1;
	localparam logic [RES_W-1:0] RES_2000 = 4'h2;
	localparam logic [RES_W-1:0] RES_12800 = 4'h5;
	localparam logic [RES_W-1:0] RES_50800 = 4'hE;
	localparam logic [RES_W-1:0] RES_LAST = 4'hE;
	// Microsteps per full step, indexed by resolution code
	localparam logic [7:0] MS_TABLE [0:14] = '{8'h01, 8'h02, 8'h0A, 8'h19, 8'h32,
		8'h40, 8'h5A, 8'h64, 8'h6C, 8'h7D, 8'h7F, 8'h80, 8'hB4, 8'hFA, 8'hFE};
	localparam logic [7:0] MS_FINEST = 8'hFE;
	// Position within one electrical cycle (four full steps)
	localparam logic [POS_W-1:0] POS_ZERO = 10'h000;
	// Oscillator rate: step period = base + scale * (max - speed)
	localparam logic [23:0] OSC_BASE = 24'h0009C4;
	localparam logic [23:0] OSC_SCALE = 24'h000064;
	localparam logic [ADC_W-1:0] ADC_MAX = 10'h3FF;
	// Direction settle time before run, least, in ns
	localparam int DIR_SETUP_NS = 10000;
	localparam int DIR_SETUP_CYC = (DIR_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
endpackage

/* File: core/dams_axis.sv */
// One axis: step decode, oscillator, microstep position and sine phase currents.
// Assumes inputs already synchronised to sys_clk and a 10-bit speed sample.
module dams_axis
	import dams_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Configuration
	input wire logic [dams_pkg::RES_W-1:0] res_sel,
	input wire logic osc_mode,
	input wire logic fixed_speed_en,
	input wire logic [dams_pkg::ADC_W-1:0] fixed_speed,
	// Synchronised inputs
	input wire logic step_run,
	input wire logic dir,
	input wire logic [dams_pkg::ADC_W-1:0] speed_adc,
	// Outputs
	output logic [dams_pkg::CUR_W:0] cur_a,
	output logic [dams_pkg::CUR_W:0] cur_b,
	output logic step_pulse
);
	typedef enum logic [1:0] {DAMS_IDLE, DAMS_SETTLE, DAMS_RUN} dams_osc_e;
	dams_osc_e state;
	dams_osc_e next_state;
	logic step_d;
	logic run_dir;
	logic [15:0] settle_cnt;
	logic [23:0] period_cnt;
	logic [31:0] phase;
	logic [dams_pkg::RES_W-1:0] eff_res;
	logic [7:0] ms_per;
	logic [dams_pkg::ADC_W-1:0] speed;
	logic [23:0] period;
	logic adv;
	logic adv_dir;
	logic [31:0] incr;
	logic [7:0] ang;
	logic [1:0] quad;
	logic [7:0] sin_a;
	logic [7:0] sin_b;
	logic [31:0] phase_r;
	// Half an angle step: absorbs the rounding of incr in either direction
	localparam logic [31:0] ANG_HALF = 32'h00200000;
	localparam logic [8:0] ANG_CREST = 9'h100;

	// Quarter sine, 0..90 degrees in 256 steps; 256 itself is the crest
	function automatic logic [7:0] qsin(input logic [8:0] x);
		real r;
		r = $sin(3.14159265 / 2.0 * x / 256.0) * 255.0;
		return 8'(int'(r));
	endfunction

	assign eff_res = osc_mode ? RES_12800 : res_sel;
	assign ms_per = (eff_res > RES_LAST) ? MS_FINEST : MS_TABLE[eff_res];
	assign speed = fixed_speed_en ? fixed_speed : speed_adc;
	assign period = OSC_BASE + 24'(OSC_SCALE * 24'(ADC_MAX - speed));
	assign adv = osc_mode ? (state == DAMS_RUN && period_cnt == 24'h0)
		: (step_run && !step_d);
	assign adv_dir = osc_mode ? run_dir : dir;
	// One microstep is 2^32/(4*ms_per) of the electrical cycle
	assign incr = 32'((64'h40000000 + 64'(ms_per) - 64'h1) / 64'(ms_per));
	// Rounded, so a position a hair below a step boundary still reads as on it
	assign phase_r = phase + ANG_HALF;
	assign quad = phase_r[31:30];
	assign ang = phase_r[29:22];
	// Full step sits at 45 degrees so both phases carry current
	assign sin_a = quad[0] ? qsin(ANG_CREST - 9'(ang)) : qsin(9'(ang));
	assign sin_b = quad[0] ? qsin(9'(ang)) : qsin(ANG_CREST - 9'(ang));

	always_comb begin
		next_state = state;
		case (state)
			DAMS_IDLE: if (osc_mode && step_run) next_state = DAMS_SETTLE;
			DAMS_SETTLE: if (!step_run) next_state = DAMS_IDLE;
				else if (settle_cnt == 16'h0) next_state = DAMS_RUN;
			DAMS_RUN: if (!step_run || !osc_mode) next_state = DAMS_IDLE;
			default: next_state = DAMS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= DAMS_IDLE;
			step_d <= 1'b0;
			run_dir <= 1'b0;
			settle_cnt <= 16'h0;
			period_cnt <= 24'h0;
			phase <= 32'h20000000;
			cur_a <= '0;
			cur_b <= '0;
			step_pulse <= 1'b0;
		end else begin
			state <= next_state;
			step_d <= step_run;
			if (state == DAMS_IDLE)
				settle_cnt <= 16'(DIR_SETUP_CYC);
			else if (settle_cnt != 16'h0)
				settle_cnt <= settle_cnt - 16'h1;
			// Direction latched at run, after settle; held until run drops
			if (state == DAMS_SETTLE && settle_cnt == 16'h0)
				run_dir <= dir;
			// Reload one short: the zero cycle itself completes the period
			period_cnt <= (adv || state != DAMS_RUN) ? period - 24'h1 : period_cnt - 24'h1;
			if (adv)
				phase <= adv_dir ? phase + incr : phase - incr;
			step_pulse <= adv;
			// Sign in top bit: A (sine) negative in quadrants 2,3; B (cosine) in 1,2
			cur_a <= {quad[1], sin_a};
			cur_b <= {quad == 2'h1 || quad == 2'h2, sin_b};
		end
	end

	property p_osc_res;
		@(posedge sys_clk) disable iff (rst) osc_mode |-> eff_res == RES_12800;
	endproperty
	a_osc_res: assert property (p_osc_res) else $error("oscillator resolution");
	property p_edge_step;
		@(posedge sys_clk) disable iff (rst)
			(!osc_mode && step_run && !step_d) |=> step_pulse;
	endproperty
	a_edge_step: assert property (p_edge_step) else $error("step edge missed");
	property p_no_step;
		@(posedge sys_clk) disable iff (rst)
			(!osc_mode && !(step_run && !step_d)) |=> !step_pulse;
	endproperty
	a_no_step: assert property (p_no_step) else $error("spurious step");
	property p_fixed;
		@(posedge sys_clk) disable iff (rst) fixed_speed_en |-> speed == fixed_speed;
	endproperty
	a_fixed: assert property (p_fixed) else $error("analog not ignored");
	property p_dir_hold;
		@(posedge sys_clk) disable iff (rst)
			(state == DAMS_RUN && $past(state) == DAMS_RUN) |-> $stable(run_dir);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction changed in run");
	property p_finest;
		@(posedge sys_clk) disable iff (rst)
			(!osc_mode && res_sel == RES_50800) |-> ms_per == MS_FINEST;
	endproperty
	a_finest: assert property (p_finest) else $error("finest resolution");
	property p_tenth;
		@(posedge sys_clk) disable iff (rst)
			(!osc_mode && res_sel == RES_2000) |-> ms_per == 8'h0A;
	endproperty
	a_tenth: assert property (p_tenth) else $error("2000 setting");
	property p_full_both;
		@(posedge sys_clk) disable iff (rst)
			(!osc_mode && res_sel == RES_FULL) |=> (cur_a[7:0] != 8'h0 && cur_b[7:0] != 8'h0);
	endproperty
	a_full_both: assert property (p_full_both) else $error("full step phase off");
endmodule

/* File: core/dams_top.sv */
// Function
// - Fifteen resolutions: full, half, thirteen microstep
// - Finest setting gives 254 microsteps per step
// - Microstep commands per-phase current per position
// - Half step alternates two-phase and one-phase
// - Full step energizes both phases always; here only from a full-step phase, which a resolution change does not realign
// - 2000 setting is one tenth step
// - Oscillator mode forces 12,800 steps per revolution
// - Oscillator speed comes from analog input
// - Fixed speed option ignores analog input
// - Step on each rising step edge
// - Microstep currents follow pure sine
// - Analog speed digitised to ten bits
//
// Top of the two-axis sequencer; configuration bits are plain ports.
// Assumes step, direction pins asynchronous; ADC words arrive on sys_clk.
module dams_top
	import dams_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Per-axis configuration
	input wire logic [dams_pkg::RES_W-1:0] res_sel_1,
	input wire logic [dams_pkg::RES_W-1:0] res_sel_2,
	input wire logic osc_mode_1,
	input wire logic osc_mode_2,
	input wire logic fixed_speed_en_1,
	input wire logic fixed_speed_en_2,
	input wire logic [dams_pkg::ADC_W-1:0] fixed_speed_1,
	input wire logic [dams_pkg::ADC_W-1:0] fixed_speed_2,
	// Pins
	input wire logic step_run_1,
	input wire logic step_run_2,
	input wire logic dir_1,
	input wire logic dir_2,
	// 10-bit analog samples
	input wire logic [dams_pkg::ADC_W-1:0] adc_1,
	input wire logic [dams_pkg::ADC_W-1:0] adc_2,
	// Phase currents (sign bit above magnitude), step pulses, config error
	output logic [dams_pkg::CUR_W:0] cur_a_1,
	output logic [dams_pkg::CUR_W:0] cur_b_1,
	output logic [dams_pkg::CUR_W:0] cur_a_2,
	output logic [dams_pkg::CUR_W:0] cur_b_2,
	output logic step_pulse_1,
	output logic step_pulse_2,
	output logic cfg_error
);
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [dams_pkg::ADC_W-1:0] adc_q1;
	logic [dams_pkg::ADC_W-1:0] adc_q2;
	logic coarse_1;
	logic coarse_2;
	logic bad_cfg;

	// Host keeps full/half on both axes together; flagged if it does not
	assign coarse_1 = !osc_mode_1 && res_sel_1 <= RES_HALF;
	assign coarse_2 = !osc_mode_2 && res_sel_2 <= RES_HALF;
	assign bad_cfg = coarse_1 != coarse_2;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			adc_q1 <= '0;
			adc_q2 <= '0;
			cfg_error <= 1'b0;
		end else begin
			sync1 <= {step_run_2, step_run_1, dir_2, dir_1};
			sync2 <= sync1;
			adc_q1 <= adc_1;
			adc_q2 <= adc_2;
			cfg_error <= bad_cfg;
		end
	end

	dams_axis u_axis1 (
		.sys_clk(sys_clk),
		.rst(rst),
		.res_sel(res_sel_1),
		.osc_mode(osc_mode_1),
		.fixed_speed_en(fixed_speed_en_1),
		.fixed_speed(fixed_speed_1),
		.step_run(sync2[2]),
		.dir(sync2[0]),
		.speed_adc(adc_q1),
		.cur_a(cur_a_1),
		.cur_b(cur_b_1),
		.step_pulse(step_pulse_1)
	);

	dams_axis u_axis2 (
		.sys_clk(sys_clk),
		.rst(rst),
		.res_sel(res_sel_2),
		.osc_mode(osc_mode_2),
		.fixed_speed_en(fixed_speed_en_2),
		.fixed_speed(fixed_speed_2),
		.step_run(sync2[3]),
		.dir(sync2[1]),
		.speed_adc(adc_q2),
		.cur_a(cur_a_2),
		.cur_b(cur_b_2),
		.step_pulse(step_pulse_2)
	);

	property p_cfg_flag;
		@(posedge sys_clk) disable iff (rst) bad_cfg |=> cfg_error;
	endproperty
	a_cfg_flag: assert property (p_cfg_flag) else $error("config error not flagged");
	property p_adc_use;
		@(posedge sys_clk) disable iff (rst) 1'b1 |=> adc_q1 == $past(adc_1);
	endproperty
	a_adc_use: assert property (p_adc_use) else $error("adc sample lost");
endmodule

/* File: bench/dams_indexer.sv */
// Step and run source standing in for the indexer or PLC at one axis.
// Assumes one caller process; pins change only at falling edges.
module dams_indexer
	import dams_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Pins
	output logic step,
	output logic dir
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		step = 1'b0;
		dir = 1'b0;
	end
	// Widths vary so both prompt and slow sources are seen
	task pulse(input logic d);
		dir = d;
		repeat (2) @(negedge sys_clk);
		step = 1'b1;
		repeat ($urandom_range(3, 5)) @(negedge sys_clk);
		step = 1'b0;
		repeat ($urandom_range(3, 5)) @(negedge sys_clk);
	endtask
	// Direction settles for the whole window before run moves
	task run(input logic on, input logic d);
		dir = d;
		repeat (DIR_SETUP_CYC + 2) @(negedge sys_clk);
		step = on;
	endtask
endmodule

/* File: bench/dams_top_tb.sv */
// Bench for the sequencer: every resolution on axis 1, oscillator on axis 2.
// Assumes a 25 MHz clock; inputs move at falling edges.
module dams_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dams_pkg::*;
	logic sys_clk, rst, osc_mode_1, osc_mode_2, fixed_speed_en_1, fixed_speed_en_2;
	logic [RES_W-1:0] res_sel_1, res_sel_2;
	logic [ADC_W-1:0] fixed_speed_1, fixed_speed_2, adc_1, adc_2;
	logic [CUR_W:0] cur_a_1, cur_b_1, cur_a_2, cur_b_2;
	logic step_run_1, step_run_2, dir_1, dir_2, step_pulse_1, step_pulse_2, cfg_error;
	logic [1:0] notes[$];
	logic [1:0] e;
	logic fwd;
	int n_errors = 0;
	int compares = 0;
	int n, m, r2;
	dams_top i_dut (.sys_clk(sys_clk), .rst(rst), .res_sel_1(res_sel_1),
		.res_sel_2(res_sel_2), .osc_mode_1(osc_mode_1), .osc_mode_2(osc_mode_2),
		.fixed_speed_en_1(fixed_speed_en_1), .fixed_speed_en_2(fixed_speed_en_2),
		.fixed_speed_1(fixed_speed_1), .fixed_speed_2(fixed_speed_2),
		.step_run_1(step_run_1), .step_run_2(step_run_2), .dir_1(dir_1), .dir_2(dir_2),
		.adc_1(adc_1), .adc_2(adc_2), .cur_a_1(cur_a_1), .cur_b_1(cur_b_1),
		.cur_a_2(cur_a_2), .cur_b_2(cur_b_2), .step_pulse_1(step_pulse_1),
		.step_pulse_2(step_pulse_2), .cfg_error(cfg_error));
	dams_indexer i_ax1 (.sys_clk(sys_clk), .step(step_run_1), .dir(dir_1));
	dams_indexer i_ax2 (.sys_clk(sys_clk), .step(step_run_2), .dir(dir_2));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wait_pulse(output int cnt);
		cnt = 0;
		do begin
			@(negedge sys_clk);
			cnt++;
		end while (step_pulse_2 !== 1'b1 && cnt < 4000);
		if (cnt >= 4000) begin
			n_errors++;
			give_verdict;
		end
	endtask
	// Currents move one cycle after the pulse, so each note is judged then
	always @(negedge sys_clk) if (step_pulse_1 === 1'b1) begin
		@(negedge sys_clk);
		check(notes.size() > 0, 1);
		if (notes.size() > 0) begin
			e = notes.pop_front();
			if (e == 2'h1) check(cur_a_1[CUR_W-1:0], cur_b_1[CUR_W-1:0]);
			if (e == 2'h2) check((cur_a_1[CUR_W-1:0] == 0) ^ (cur_b_1[CUR_W-1:0] == 0), 1);
			if (e == 2'h2) check(cur_a_1[CUR_W-1:0] | cur_b_1[CUR_W-1:0], {CUR_W{1'b1}});
		end
	end
	initial begin
		#(40 * 90000);
		n_errors++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'hF047CF22));
		rst = 1'b1;
		osc_mode_1 = 1'b0;
		osc_mode_2 = 1'b0;
		fixed_speed_en_1 = $urandom;
		fixed_speed_en_2 = 1'b1;
		res_sel_1 = 4'h0;
		res_sel_2 = 4'h0;
		fixed_speed_1 = $urandom;
		fixed_speed_2 = ADC_MAX;
		adc_1 = $urandom;
		adc_2 = $urandom;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		check(cur_a_1, cur_b_1);
		// Each block walks two full steps, so the next starts on a full step
		for (int r = 0; r < 15; r++) begin
			res_sel_1 = r[RES_W-1:0];
			r2 = $urandom_range(0, 14);
			res_sel_2 = r2[RES_W-1:0];
			repeat (3) @(negedge sys_clk);
			check(cfg_error, (r < 2) != (r2 < 2));
			m = MS_TABLE[r];
			fwd = 1'($urandom);
			for (int k = 1; k <= 2 * m; k++) begin
				notes.push_back(k % m == 0 ? 2'h1 : (m % 2 == 0 && k % m == m / 2) ? 2'h2 : 2'h0);
				i_ax1.pulse(fwd);
			end
		end
		repeat (10) @(negedge sys_clk);
		// Axis 2 asks for full step yet must move in fine steps
		osc_mode_2 = 1'b1;
		res_sel_2 = RES_FULL;
		i_ax2.run(1'b1, $urandom);
		wait_pulse(n);
		@(negedge sys_clk);
		check(cur_a_2[CUR_W-1:0] !== cur_b_2[CUR_W-1:0], 1);
		wait_pulse(n);
		check(n, OSC_BASE - 1);
		fixed_speed_en_2 = 1'b0;
		adc_2 = ADC_MAX - 10'h001;
		wait_pulse(n);
		wait_pulse(n);
		check(n, OSC_BASE + OSC_SCALE);
		i_ax2.run(1'b0, 1'b0);
		check(notes.size(), 0);
		give_verdict;
	end
endmodule
